// ==== rtl/psmcr_params.svh ====
// Register offsets, field positions, reset values and timing counts for the PHY status and MMD control bank.
`ifndef PSMCR_PARAMS_SVH
`define PSMCR_PARAMS_SVH

// Management register offsets.
`define PSMCR_OFF_GEN_STATUS   5'h0A
`define PSMCR_OFF_MMD_CTRL     5'h0D
`define PSMCR_OFF_MMD_ADDR     5'h0E
`define PSMCR_OFF_GIG_ABILITY  5'h0F
`define PSMCR_OFF_PHY_CTRL     5'h10

// Reset values and the fixed gigabit ability value.
`define PSMCR_RST_GEN_STATUS   16'h0000
`define PSMCR_RST_MMD_CTRL     16'h0000
`define PSMCR_RST_MMD_ADDR     16'h0000
`define PSMCR_VAL_GIG_ABILITY  16'hF000
`define PSMCR_RST_PHY_CTRL     16'h5048

// MMD access control fields.
`define PSMCR_FN_HI            15
`define PSMCR_FN_LO            14
`define PSMCR_DEV_HI           4
`define PSMCR_DEV_LO           0

// PHY specific control fields.
`define PSMCR_TXD_HI           15
`define PSMCR_TXD_LO           14
`define PSMCR_RXD_HI           13
`define PSMCR_RXD_LO           12
`define PSMCR_FORCE_LINK       10
`define PSMCR_PWR_HI           9
`define PSMCR_PWR_LO           8
`define PSMCR_XO_HI            6
`define PSMCR_XO_LO            5
`define PSMCR_CLK_OFF          4
`define PSMCR_LD_INV           1
`define PSMCR_JAB_OFF          0

// Cycles the strap is watched after reset before it is taken.
`define PSMCR_STRAP_WAIT       2'h3

`endif

// ==== rtl/psmcr_pkg.sv ====
// Types shared by the PHY status and MMD control register bank.
package psmcr_pkg;

    // MMD function field codes.
    typedef enum logic [1:0] {
        PSMCR_FN_ADDR    = 2'h0,
        PSMCR_FN_DATA    = 2'h1,
        PSMCR_FN_INC_RW  = 2'h2,
        PSMCR_FN_INC_WR  = 2'h3
    } psmcr_fn_t;

    // Crossover mode, one-hot.
    typedef enum logic [2:0] {
        PSMCR_XO_MDI  = 3'h1,
        PSMCR_XO_MDIX = 3'h2,
        PSMCR_XO_AUTO = 3'h4
    } psmcr_xo_t;

    // Status from the PHY core, same clock.
    typedef struct packed {
        logic ms_fault_event;   // Pulse: master/slave fault seen.
        logic ms_master;        // Level: resolved to master.
        logic local_ok;         // Level: local receiver OK.
        logic remote_ok;        // Level: remote receiver OK.
        logic lp_full;          // Level: partner gig full duplex.
        logic lp_half;          // Level: partner gig half duplex.
        logic idle_err;         // Pulse: one idle error.
        logic speed_1g;         // Level: running at 1G.
        logic link_up;          // Level: normal link status.
        logic mirror_mode;      // Level: mirror mode active.
        logic sgmii_mode;       // Level: SGMII in use.
        logic gmii_mode;        // Level: GMII in use.
    } psmcr_core_t;

    // Decoded configuration toward the PHY core.
    typedef struct packed {
        logic [3:0] tx_depth;   // Transmit FIFO depth.
        logic       tx_en;      // Transmit FIFO in use.
        logic [3:0] rx_depth;   // Receive FIFO depth.
        logic       rx_en;      // Receive FIFO in use.
        logic       link_good;  // Link status shown to core.
        logic [1:0] power_save; // Power saving state.
        psmcr_xo_t  crossover;  // Crossover mode.
        logic       ref_clk_en; // Reference clock output runs.
        logic       ld_invert;  // Line driver inversion.
        logic       jabber_en;  // Jabber detection active.
    } psmcr_cfg_t;

    // Indirect MMD access toward the extended register set.
    typedef struct packed {
        logic [4:0]  device;    // Selected MMD.
        logic [15:0] addr;      // Held register address.
        logic [15:0] acc_addr;  // Address of the strobed access.
        logic [15:0] wdata;     // Write data.
        logic        addr_wr;   // Pulse: address loaded.
        logic        data_wr;   // Pulse: data write.
        logic        data_rd;   // Pulse: data read.
    } psmcr_mmd_t;

endpackage

// ==== rtl/psmcr_regs.sv ====
// PHY status, MMD indirect access and Phy_specific_control registers.
`timescale 1ns/1ps
`include "psmcr_params.svh"
// Behaviour
// - master/slave fault latches high, read clears
// - bit 14 shows master/slave resolution
// - bits 13 and 12 show receiver health
// - bits 11, 10 show partner gig abilities
// - idle error counter in bits 7-0
// - device field steers address/data accesses
// - function field decodes four access modes
// - function 00 maps address, else data
// - gigabit ability register reads fixed F000h
// - transmit FIFO depth from control, used with GMII at 1G or SGMII
// - receive FIFO depth, used only with SGMII
// - force link good at 1G
// - power saving state from bits 9-8
// - crossover from bits 6-5, strap reset
// - bit 1 inverts driver except mirror
// - bit 0 disables jabber detection
module psmcr_regs (
    input  wire logic               clock_in,       // Management clock.
    input  wire logic               nrst_in,        // Asynchronous reset, active low.
    input  wire logic [4:0]         reg_addr_in,    // Register number of a frame.
    input  wire logic               reg_wr_in,      // Pulse: write request.
    input  wire logic               reg_rd_in,      // Pulse: read request.
    input  wire logic [15:0]        reg_wdata_in,   // Write data.
    output logic      [15:0]        reg_rdata_out,  // Read data.
    output logic                    reg_ack_out,    // Pulse: request done.
    input  wire psmcr_pkg::psmcr_core_t core_in,    // Core status.
    input  wire logic [1:0]         xo_strap_in,    // Crossover strap pins.
    input  wire logic [15:0]        mmd_rdata_in,   // Extended register data.
    output psmcr_pkg::psmcr_mmd_t   mmd_out,        // Extended register access.
    output psmcr_pkg::psmcr_cfg_t   cfg_out         // Decoded configuration.
);
    import psmcr_pkg::*;

    // All state of the bank.
    typedef struct packed {
        logic        fault;     // Latched fault flag.
        logic [7:0]  idle_cnt;  // Idle error count.
        psmcr_fn_t   func;      // MMD function.
        logic [15:0] ctrl;      // Phy_specific_control word.
        logic [15:0] rdata;     // Read answer.
        logic        ack;       // Answer strobe.
        psmcr_mmd_t  mmd;       // MMD access port.
        psmcr_cfg_t  cfg;       // Decoded configuration.
        logic [1:0]  strap1;    // Strap sync stage one.
        logic [1:0]  strap2;    // Strap sync stage two.
        logic [1:0]  strap3;    // Strap sync stage three.
        logic [1:0]  strap_cnt; // Cycles since release.
        logic        strap_done;// Strap has been taken.
    } psmcr_state_t;

    psmcr_state_t state_reg;    // Registered state.
    psmcr_state_t state_next;   // Next state.

    // Maps a two-bit FIFO depth code to a byte count.
    function automatic logic [3:0] depth_of(input logic [1:0] code);
        logic [3:0] d;
        d = 4'h4;
        case (code)
            2'h0: d = 4'h3;
            2'h1: d = 4'h4;
            2'h2: d = 4'h6;
            default: d = 4'h8;
        endcase
        return d;
    endfunction

    // Next-state logic for the whole bank.
    always_comb begin
        state_next = state_reg;
        // Strobes last one cycle.
        state_next.ack = 1'b0;
        state_next.mmd.addr_wr = 1'b0;
        state_next.mmd.data_wr = 1'b0;
        state_next.mmd.data_rd = 1'b0;

        // The strap pins pass three flops.
        state_next.strap1 = xo_strap_in;
        state_next.strap2 = state_reg.strap1;
        state_next.strap3 = state_reg.strap2;
        // The strap is taken once, after release, when stages agree.
        if (!state_reg.strap_done) begin
            if (state_reg.strap_cnt != `PSMCR_STRAP_WAIT) begin
                state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
            end else if (state_reg.strap2 == state_reg.strap3) begin
                state_next.ctrl[`PSMCR_XO_HI:`PSMCR_XO_LO] = state_reg.strap3;
                state_next.strap_done = 1'b1;
            end
        end

        // The idle error counter saturates rather than wrapping.
        if (core_in.idle_err && state_reg.idle_cnt != 8'hFF) begin
            state_next.idle_cnt = state_reg.idle_cnt + 8'h01;
        end

        // A write wins over a read offered in the same cycle.
        if (reg_wr_in) begin
            state_next.ack = 1'b1;
            case (reg_addr_in)
                // Function and device select; reserved bits drop.
                `PSMCR_OFF_MMD_CTRL: begin
                    state_next.func = psmcr_fn_t'(reg_wdata_in[`PSMCR_FN_HI:`PSMCR_FN_LO]);
                    state_next.mmd.device = reg_wdata_in[`PSMCR_DEV_HI:`PSMCR_DEV_LO];
                end
                // Address or data, by function.
                `PSMCR_OFF_MMD_ADDR: begin
                    state_next.mmd.wdata = reg_wdata_in;
                    if (state_reg.func == PSMCR_FN_ADDR) begin
                        state_next.mmd.addr = reg_wdata_in;
                        state_next.mmd.addr_wr = 1'b1;
                    end else begin
                        state_next.mmd.acc_addr = state_reg.mmd.addr;
                        state_next.mmd.data_wr = 1'b1;
                        // Both increment modes advance on write.
                        if (state_reg.func[1]) begin
                            state_next.mmd.addr = state_reg.mmd.addr + 16'h0001;
                        end
                    end
                end
                // Control word; all bits are writable.
                `PSMCR_OFF_PHY_CTRL: begin
                    state_next.ctrl = reg_wdata_in;
                end
                // Read-only or unmapped: ignored.
                default: begin
                end
            endcase
        end else if (reg_rd_in) begin
            state_next.ack = 1'b1;
            case (reg_addr_in)
                // General status; the read clears the fault latch.
                `PSMCR_OFF_GEN_STATUS: begin
                    state_next.rdata = {state_reg.fault, core_in.ms_master,
                                        core_in.local_ok, core_in.remote_ok,
                                        core_in.lp_full, core_in.lp_half,
                                        2'h0, state_reg.idle_cnt};
                    state_next.fault = 1'b0;
                end
                // Access control with reserved bits as zero.
                `PSMCR_OFF_MMD_CTRL: begin
                    state_next.rdata = {state_reg.func, 9'h000, state_reg.mmd.device};
                end
                // Address or data, by function.
                `PSMCR_OFF_MMD_ADDR: begin
                    if (state_reg.func == PSMCR_FN_ADDR) begin
                        state_next.rdata = state_reg.mmd.addr;
                    end else begin
                        state_next.rdata = mmd_rdata_in;
                        state_next.mmd.acc_addr = state_reg.mmd.addr;
                        state_next.mmd.data_rd = 1'b1;
                        // Only the read-and-write mode advances on read.
                        if (state_reg.func == PSMCR_FN_INC_RW) begin
                            state_next.mmd.addr = state_reg.mmd.addr + 16'h0001;
                        end
                    end
                end
                // Fixed gigabit abilities.
                `PSMCR_OFF_GIG_ABILITY: begin
                    state_next.rdata = `PSMCR_VAL_GIG_ABILITY;
                end
                // Control word.
                `PSMCR_OFF_PHY_CTRL: begin
                    state_next.rdata = state_reg.ctrl;
                end
                // Unmapped registers read as zero.
                default: begin
                    state_next.rdata = 16'h0000;
                end
            endcase
        end

        // A fault in the clearing cycle still latches.
        if (core_in.ms_fault_event) begin
            state_next.fault = 1'b1;
        end

        // Decode the control word for the core.
        state_next.cfg.tx_depth = depth_of(state_reg.ctrl[`PSMCR_TXD_HI:`PSMCR_TXD_LO]);
        state_next.cfg.tx_en = (core_in.speed_1g && core_in.gmii_mode) || core_in.sgmii_mode;
        state_next.cfg.rx_depth = depth_of(state_reg.ctrl[`PSMCR_RXD_HI:`PSMCR_RXD_LO]);
        state_next.cfg.rx_en = core_in.sgmii_mode;
        state_next.cfg.link_good = core_in.link_up ||
                                   (state_reg.ctrl[`PSMCR_FORCE_LINK] && core_in.speed_1g);
        state_next.cfg.power_save = state_reg.ctrl[`PSMCR_PWR_HI:`PSMCR_PWR_LO];
        // Codes 2 and 3 both select automatic crossover.
        case (state_reg.ctrl[`PSMCR_XO_HI:`PSMCR_XO_LO])
            2'h0: state_next.cfg.crossover = PSMCR_XO_MDI;
            2'h1: state_next.cfg.crossover = PSMCR_XO_MDIX;
            default: state_next.cfg.crossover = PSMCR_XO_AUTO;
        endcase
        state_next.cfg.ref_clk_en = !state_reg.ctrl[`PSMCR_CLK_OFF];
        state_next.cfg.ld_invert = state_reg.ctrl[`PSMCR_LD_INV] && !core_in.mirror_mode;
        state_next.cfg.jabber_en = !state_reg.ctrl[`PSMCR_JAB_OFF];
    end

    // State register; reset loads constants only.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
            state_reg.ctrl <= `PSMCR_RST_PHY_CTRL;
            state_reg.cfg.tx_depth <= 4'h4;
            state_reg.cfg.rx_depth <= 4'h4;
            state_reg.cfg.crossover <= PSMCR_XO_AUTO;
            state_reg.cfg.ref_clk_en <= 1'b1;
            state_reg.cfg.jabber_en <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register.
    assign reg_rdata_out = state_reg.rdata;
    assign reg_ack_out = state_reg.ack;
    assign mmd_out = state_reg.mmd;
    assign cfg_out = state_reg.cfg;

    // Checks run on the management clock.
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    // A read of general status.
    sequence gen_read_s;
        reg_rd_in && !reg_wr_in && reg_addr_in == `PSMCR_OFF_GEN_STATUS;
    endsequence

    // A data write through the address/data register.
    sequence data_wr_s;
        reg_wr_in && reg_addr_in == `PSMCR_OFF_MMD_ADDR && state_reg.func != PSMCR_FN_ADDR;
    endsequence

    // A data read through the address/data register.
    sequence data_rd_s;
        reg_rd_in && !reg_wr_in && reg_addr_in == `PSMCR_OFF_MMD_ADDR && state_reg.func != PSMCR_FN_ADDR;
    endsequence

    // A fault event latches on the next edge, even in a clearing cycle.
    fault_latch_a: assert property (core_in.ms_fault_event |=> state_reg.fault)
        else $error("Fault not latched.");

    // A status read without a new event clears the latch.
    fault_clear_a: assert property (gen_read_s ##0 !core_in.ms_fault_event |=> !state_reg.fault)
        else $error("Fault not cleared by read.");

    // Status bits follow the core.
    status_bits_a: assert property (gen_read_s |=> reg_ack_out &&
                                    reg_rdata_out[14:10] == $past({core_in.ms_master, core_in.local_ok,
                                    core_in.remote_ok, core_in.lp_full, core_in.lp_half})
                                    && reg_rdata_out[9:8] == 2'h0)
        else $error("Status bits wrong.");

    // Idle count climbs by one per error.
    idle_count_a: assert property (core_in.idle_err && state_reg.idle_cnt != 8'hFF
                                   |=> state_reg.idle_cnt == $past(state_reg.idle_cnt) + 8'h01)
        else $error("Idle count not advanced.");

    // Device select takes the written field.
    device_sel_a: assert property (reg_wr_in && reg_addr_in == `PSMCR_OFF_MMD_CTRL
                                   |=> mmd_out.device == $past(reg_wdata_in[4:0]))
        else $error("Device select not loaded.");

    // Function 00 loads the address only.
    addr_map_a: assert property (reg_wr_in && reg_addr_in == `PSMCR_OFF_MMD_ADDR &&
                                 state_reg.func == PSMCR_FN_ADDR
                                 |=> mmd_out.addr_wr && !mmd_out.data_wr && mmd_out.addr == $past(reg_wdata_in))
        else $error("Address access misrouted.");

    // Data writes strobe and advance when asked.
    write_incr_a: assert property (data_wr_s |=> mmd_out.data_wr &&
                                   mmd_out.addr == $past(state_reg.mmd.addr) + {15'h0000, $past(state_reg.func[1])})
        else $error("Write increment wrong.");

    // Data reads advance only in read-and-write mode.
    read_incr_a: assert property (data_rd_s |=> mmd_out.data_rd && reg_rdata_out == $past(mmd_rdata_in) &&
                                  mmd_out.addr == $past(state_reg.mmd.addr) +
                                  {15'h0000, $past(state_reg.func) == PSMCR_FN_INC_RW})
        else $error("Read increment wrong.");

    // Ability register is fixed.
    ability_a: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == `PSMCR_OFF_GIG_ABILITY
                                |=> reg_rdata_out == 16'hF000)
        else $error("Ability value wrong.");

    // Forced link at 1G shows two cycles on.
    force_link_a: assert property (reg_wr_in && reg_addr_in == `PSMCR_OFF_PHY_CTRL && reg_wdata_in[10]
                                   ##1 core_in.speed_1g |=> cfg_out.link_good)
        else $error("Link not forced.");

    // Control bits reach the core two cycles after a write.
    ctrl_decode_a: assert property (reg_wr_in && reg_addr_in == `PSMCR_OFF_PHY_CTRL ##1 !reg_wr_in
                                    |=> cfg_out.ref_clk_en == !$past(state_reg.ctrl[4]) &&
                                    cfg_out.jabber_en == !$past(state_reg.ctrl[0]) &&
                                    cfg_out.power_save == $past(state_reg.ctrl[9:8]) &&
                                    cfg_out.rx_depth == depth_of($past(state_reg.ctrl[13:12])))
        else $error("Control decode wrong.");

    // Mirror mode blocks inversion.
    mirror_inv_a: assert property (core_in.mirror_mode |=> !cfg_out.ld_invert)
        else $error("Inversion in mirror mode.");

endmodule

// ==== sim/psmcr_mmd_model.sv ====
// Behavioural extended register set that answers the indirect MMD accesses.
`timescale 1ns/1ps
module psmcr_mmd_model (
    input  wire logic                  clock_in,  // Management clock.
    input  wire psmcr_pkg::psmcr_mmd_t mmd_in,    // Access from the bank.
    output logic [15:0]                rdata_out  // Read data for the held address.
);
    import psmcr_pkg::*;
    logic [15:0] mem [256];  // Extended registers, low address byte only.
    // Preload a pattern that differs per address.
    initial begin
        for (int k = 0; k < 256; k++) begin
            mem[k] = {8'hC3, 8'(k)};
        end
    end
    // Data writes land at the address of the strobed access.
    always @(posedge clock_in) begin
        if (mmd_in.data_wr) begin
            mem[mmd_in.acc_addr[7:0]] <= mmd_in.wdata;
        end
    end
    // Only the vendor device answers; any other device reads the inverted word.
    assign rdata_out = (mmd_in.device == 5'h1F) ? mem[mmd_in.addr[7:0]] : ~mem[mmd_in.addr[7:0]];
endmodule

// ==== sim/psmcr_regs_test.sv ====
// Self-checking bench for the PHY status and MMD control register bank.
`timescale 1ns/1ps
`include "psmcr_params.svh"
module psmcr_regs_test;
    import psmcr_pkg::*;
    logic        clock_in  = 1'b0;    // Management clock.
    logic        nrst_in   = 1'b0;    // Reset, active low.
    logic [4:0]  reg_addr  = 5'h00;   // Register number.
    logic        reg_wr    = 1'b0;    // Write strobe.
    logic        reg_rd    = 1'b0;    // Read strobe.
    logic [15:0] reg_wdata = 16'h0000; // Write data.
    logic [15:0] reg_rdata;           // Read answer.
    logic        reg_ack;             // Request done.
    psmcr_core_t core      = '0;      // Core status driven by the bench.
    psmcr_core_t c;                   // Staging copy of the core status.
    logic [15:0] mmd_rdata;           // Extended register data.
    psmcr_mmd_t  mmd;                 // Extended register access.
    psmcr_cfg_t  cfg;                 // Decoded configuration.
    int          err_count = 0;       // Mismatches.
    int          checks    = 0;       // Comparisons.
    int          idle_tot  = 0;       // Expected idle error count.
    int          k;                   // Idle pulse length.
    logic [31:0] seed      = 32'h75A0; // Random state.
    logic [15:0] rd, w, a;            // Read word, random word, MMD address.

    psmcr_regs u_psmcr_regs (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .reg_ack_out(reg_ack),
        .core_in(core), .xo_strap_in(2'h1), .mmd_rdata_in(mmd_rdata), .mmd_out(mmd), .cfg_out(cfg));
    psmcr_mmd_model u_psmcr_mmd_model (.clock_in(clock_in), .mmd_in(mmd), .rdata_out(mmd_rdata));

    // Free-running clock of 10 ns.
    always #5 clock_in = ~clock_in;

    // Xorshift source, repeatable from the fixed start value.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected decoded configuration for a control word and the present core status.
    function automatic psmcr_cfg_t exp_cfg(input logic [15:0] v);
        logic [3:0] dm [4] = '{4'h3, 4'h4, 4'h6, 4'h8};
        psmcr_cfg_t e;
        e.tx_depth   = dm[v[15:14]];
        e.tx_en      = (core.speed_1g & core.gmii_mode) | core.sgmii_mode;
        e.rx_depth   = dm[v[13:12]];
        e.rx_en      = core.sgmii_mode;
        e.link_good  = core.link_up | (v[10] & core.speed_1g);
        e.power_save = v[9:8];
        e.crossover  = (v[6:5] == 2'h0) ? PSMCR_XO_MDI : ((v[6:5] == 2'h1) ? PSMCR_XO_MDIX : PSMCR_XO_AUTO);
        e.ref_clk_en = ~v[4];
        e.ld_invert  = v[1] & ~core.mirror_mode;
        e.jabber_en  = ~v[0];
        return e;
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One register request, held until its taking edge; the answer is kept in rd.
    task automatic acc(input logic wr, input logic [4:0] ad, input logic [15:0] wd);
        int n;
        @(posedge clock_in);
        reg_wr    <= wr;
        reg_rd    <= ~wr;
        reg_addr  <= ad;
        reg_wdata <= wd;
        @(posedge clock_in);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        n = 0;
        #1;
        while (reg_ack !== 1'b1 && n < 4) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        chk("ack", 32'(reg_ack), 32'h1);
        rd = reg_rdata;
    endtask

    // Reads a register and compares the answer.
    task automatic rdchk(input logic [4:0] ad, input logic [15:0] exp, input string name);
        acc(1'b0, ad, 16'h0000);
        chk(name, 32'(rd), 32'(exp));
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        test_done();
    end

    // Main sequence.
    initial begin
        repeat (5) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        rdchk(`PSMCR_OFF_GEN_STATUS, 16'h0000, "gen_status_rst");
        rdchk(`PSMCR_OFF_MMD_ADDR, 16'h0000, "mmd_addr_rst");
        rdchk(`PSMCR_OFF_PHY_CTRL, 16'h5028, "phy_ctrl_rst");
        chk("cfg_rst", 32'(cfg), 32'(exp_cfg(16'h5028)));
        acc(1'b1, `PSMCR_OFF_GIG_ABILITY, 16'h0FFF);
        acc(1'b1, `PSMCR_OFF_GEN_STATUS, 16'hFFFF);
        rdchk(`PSMCR_OFF_GIG_ABILITY, 16'hF000, "gig_ability");
        rdchk(5'h1F, 16'h0000, "unmapped");
        // Status levels, fault pulses and idle error bursts; the last burst saturates.
        for (int i = 0; i < 6; i++) begin
            w = 16'(xs());
            k = (i == 5) ? 300 : 1 + w[15:13];
            c = psmcr_core_t'(w[11:0] & 12'h7DF);
            c.ms_fault_event = i[0];
            c.idle_err = 1'b1;
            @(posedge clock_in);
            core <= c;
            for (int j = 1; j <= k; j++) begin
                @(posedge clock_in);
                c.ms_fault_event = 1'b0;
                c.idle_err = (j < k);
                core <= c;
            end
            idle_tot = (idle_tot + k > 255) ? 255 : idle_tot + k;
            w = {i[0], c.ms_master, c.local_ok, c.remote_ok, c.lp_full, c.lp_half, 2'b00, 8'(idle_tot)};
            rdchk(`PSMCR_OFF_GEN_STATUS, w, "gen_status");
            rdchk(`PSMCR_OFF_GEN_STATUS, {1'b0, w[14:0]}, "gen_status_clr");
        end
        // Control word: every depth, power and crossover code, random other bits and core modes.
        for (int i = 0; i < 8; i++) begin
            w = (16'(xs()) & 16'h0C9F) | {i[1:0], i[1:0], 2'b00, i[1:0], 1'b0, i[1:0], 5'h00};
            c = psmcr_core_t'(12'(xs()) & 12'h7DF);
            @(posedge clock_in);
            core <= c;
            acc(1'b1, `PSMCR_OFF_PHY_CTRL, w);
            repeat (2) @(posedge clock_in);
            #1;
            chk("cfg", 32'(cfg), 32'(exp_cfg(w)));
            rdchk(`PSMCR_OFF_PHY_CTRL, w, "phy_ctrl");
        end
        // Indirect access to the vendor set, through every function code.
        w = 16'(xs());
        a = {8'h00, w[7:4], 4'h0};
        acc(1'b1, `PSMCR_OFF_MMD_CTRL, 16'h3FFF);
        rdchk(`PSMCR_OFF_MMD_CTRL, 16'h001F, "mmd_ctrl");
        chk("mmd_dev", 32'(mmd.device), 32'h1F);
        acc(1'b1, `PSMCR_OFF_MMD_ADDR, a);
        chk("held_addr", 32'(mmd.addr), 32'(a));
        acc(1'b1, `PSMCR_OFF_MMD_CTRL, 16'h801F);
        acc(1'b1, `PSMCR_OFF_MMD_ADDR, w);
        acc(1'b1, `PSMCR_OFF_MMD_ADDR, ~w);
        chk("inc_rw_wr", 32'(mmd.addr), 32'(a + 16'h2));
        acc(1'b1, `PSMCR_OFF_MMD_CTRL, 16'h001F);
        acc(1'b1, `PSMCR_OFF_MMD_ADDR, a);
        acc(1'b1, `PSMCR_OFF_MMD_CTRL, 16'h401F);
        rdchk(`PSMCR_OFF_MMD_ADDR, w, "data_noinc");
        chk("noinc_addr", 32'(mmd.addr), 32'(a));
        acc(1'b1, `PSMCR_OFF_MMD_CTRL, 16'h801F);
        rdchk(`PSMCR_OFF_MMD_ADDR, w, "inc_rd0");
        rdchk(`PSMCR_OFF_MMD_ADDR, ~w, "inc_rd1");
        acc(1'b1, `PSMCR_OFF_MMD_CTRL, 16'hC01F);
        rdchk(`PSMCR_OFF_MMD_ADDR, {8'hC3, a[7:0] + 8'h2}, "inc_wr_rd");
        chk("inc_wr_rd_addr", 32'(mmd.addr), 32'(a + 16'h2));
        acc(1'b1, `PSMCR_OFF_MMD_ADDR, 16'h1234);
        chk("inc_wr_addr", 32'(mmd.addr), 32'(a + 16'h3));
        acc(1'b1, `PSMCR_OFF_MMD_CTRL, 16'h0005);
        rdchk(`PSMCR_OFF_MMD_ADDR, a + 16'h3, "addr_read");
        chk("other_dev", 32'(mmd.device), 32'h05);
        test_done();
    end
endmodule
